// ---- common/dplc_defines.svh ----
// Register indices, field positions and timing constants for the
// loop supervision block. Assumes inclusion by its bare name.
`ifndef DPLC_DEFINES_SVH
`define DPLC_DEFINES_SVH

// Register indices; byte address is four times the index
`define DPLC_IX_REFFREQ  16'h0202
`define DPLC_IX_STAB     16'h0206
`define DPLC_IX_CTRL     16'h0010
`define DPLC_IX_FTHR     16'h0011
`define DPLC_IX_RATE     16'h0012
`define DPLC_IX_CLMIN    16'h0013
`define DPLC_IX_CLMAX    16'h0014
`define DPLC_IX_HIST     16'h0015
`define DPLC_IX_STAT     16'h0016
`define DPLC_IX_AVG      16'h0017

// Control fields
`define DPLC_CTRL_HOLD   0
`define DPLC_CTRL_COMMIT 1

// Reset values
`define DPLC_RST_CLMAX   24'hFF_FFFF
`define DPLC_RST_RATE    16'h0101
`define DPLC_RST_HIST    4'h4

// Lock level marks, 13-bit two's complement
`define DPLC_LVL_FULL    13'h0800
`define DPLC_LVL_EMPTY   13'h1800
`define DPLC_LVL_HIGH    13'h0400
`define DPLC_LVL_LOW     13'h1C00

// Stability period unit is one millisecond
`define DPLC_MS_NS       1000000
`define DPLC_CLK_NS      50

`endif

// ---- common/dplc_pkg.sv ----
// Types shared by the loop supervision block.
// Assumes nothing beyond a SystemVerilog compiler.
package dplc_pkg;

	typedef enum logic [2:0]
	{
		dplc_st_free    = 3'b000,
		dplc_st_closed  = 3'b001,
		dplc_st_hold    = 3'b010,
		dplc_st_switch  = 3'b011,
		dplc_st_recover = 3'b100
	} dplc_state_t;

endpackage

// ---- hw/dplc_lock_det.sv ----
// Fill/drain lock detector driven by period-deviation samples.
// Assumes samples and settings come from logic on the same clock.
`timescale 1ns/1ps
`include "dplc_defines.svh"

module dplc_lock_det
	import dplc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Samples and settings
	input  wire logic        sample_valid,
	input  wire logic [23:0] sample_mag,
	input  wire logic [23:0] threshold,
	input  wire logic [7:0]  fill,
	input  wire logic [7:0]  drain,
	// Loop mode
	input  wire logic        force_unlock,
	input  wire logic        freeze,
	// Indication
	output logic             locked
);

	logic signed [13:0] sum;
	logic signed [12:0] level;
	logic signed [12:0] next_level;

	always_comb
	begin
		sum = 14'(level);
		next_level = level;
		if (sample_valid && !freeze)
		begin
			// One step per sample, by magnitude only
			if (sample_mag <= threshold)
				sum = 14'(level) + $signed({6'h00, fill});
			else
				sum = 14'(level) - $signed({6'h00, drain});
			// Saturate at both ends
			if (sum > 14'($signed(`DPLC_LVL_FULL)))
				next_level = `DPLC_LVL_FULL;
			else if (sum < 14'($signed(`DPLC_LVL_EMPTY)))
				next_level = `DPLC_LVL_EMPTY;
			else
				next_level = 13'(sum);
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n || force_unlock)
			level <= `DPLC_LVL_EMPTY;
		else
			level <= next_level;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n || force_unlock)
			locked <= 1'b0;
		else if (freeze)
			locked <= locked;
		else if (level > $signed(`DPLC_LVL_HIGH))
			locked <= 1'b1;
		else if (level < $signed(`DPLC_LVL_LOW))
			locked <= 1'b0;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_level_in_range: assert property (
		level <= $signed(`DPLC_LVL_FULL) &&
		level >= $signed(`DPLC_LVL_EMPTY))
		else $error("lock level out of range");

	a_mark_hysteresis: assert property (
		!force_unlock && !freeze && level <= $signed(`DPLC_LVL_HIGH)
		&& level >= $signed(`DPLC_LVL_LOW) |=> $stable(locked))
		else $error("lock flag moved between marks");

endmodule // dplc_lock_det

// ---- hw/dplc_top.sv ----
// Loop supervision for one digital loop instance: frequency lock
// detector, tuning-word clamp and history, loop state machine and
// system clock stability timer, with an APB register slave.
// Assumes loop filter words and deviation samples on this clock and
// an asynchronous lock level from the system clock PLL.
//
// Overview of operation
// - Frequency detector reuses fill/drain level mechanism
// - 24-bit picosecond threshold against period magnitude
// - Clamp tuning word inside programmed range
// - Average tuning words over user interval
// - Holdover drives stored averaged tuning word
// - Switchover: brief holdover, load parameters, reclose
// - Lock indication frozen during switchover
// - Holdover on missing reference or user command
// - Valid reference in holdover starts recovery
// - User holdover bit blocks automatic recovery
// - Clock reads unstable until qualified
// - Timer runs stability period after PLL lock
// - Lock loss clears and halts the timer
// - Monitors wait for stable system clock
// - Stability period write resets the timer
// - Timer restarts at commit strobe after period write, if locked
// - Saturating level from -2048 to +2048
// - Lock above +1024, unlock below -1024
// - One fill or drain step per sample
// - Free-run or holdover reports unlocked
`timescale 1ns/1ps
`include "dplc_defines.svh"

module dplc_top
	import dplc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `DPLC_MS_NS / `DPLC_CLK_NS
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// System clock PLL lock, asynchronous
	input  wire logic        internal_system_clock_pll_locked,
	// References and loop
	input  wire logic        ref_valid,
	input  wire logic [1:0]  ref_select,
	input  wire logic        period_dev_valid,
	input  wire logic [24:0] period_dev,
	input  wire logic        lf_tw_valid,
	input  wire logic [23:0] lf_tw,
	// Loop outputs
	output logic [23:0]      tw_out,
	output logic             freq_locked,
	output dplc_state_t      loop_state,
	output logic [1:0]       active_ref,
	output logic             load_params,
	output logic             internal_system_clock_stable
);

	// Registers
	logic [31:0] reg_ref_freq;
	logic [23:0] reg_stab;
	logic        user_hold;
	logic [23:0] reg_fthr;
	logic [15:0] reg_rate;
	logic [23:0] reg_clmin;
	logic [23:0] reg_clmax;
	logic [3:0]  reg_hist;

	// Bus decode
	logic        bus_wr;
	logic [15:0] bus_ix;
	logic        ix_ok;
	logic [31:0] rd_data;
	logic        stab_wr;
	logic        commit;

	// Lock synchroniser
	logic        lk_s1;
	logic        lk_s2;
	logic        lk_s3;
	logic        lock_q;

	// Stability timer
	logic [14:0] pres;
	logic [23:0] stab_cnt;
	logic        armed;

	// Loop
	dplc_state_t state;
	dplc_state_t next_state;
	logic        ref_ok;
	logic        hold_req;
	logic [23:0] tw_clamped;
	logic [23:0] avg_clamped;
	logic [24:0] dev_abs;
	logic [23:0] dev_mag;

	// History
	logic [38:0] hist_acc;
	logic [38:0] hist_sum;
	logic [14:0] hist_cnt;
	logic [15:0] hist_span;
	logic [23:0] hist_avg;
	logic        hist_valid;

	function automatic logic [23:0] clamp_tw(input logic [23:0] w,
		input logic [23:0] lo, input logic [23:0] hi);
		if (w < lo)
			return lo;
		else if (w > hi)
			return hi;
		else
			return w;
	endfunction

	assign bus_ix  = paddr[17:2];
	assign bus_wr  = psel && penable && pready && pwrite;
	assign stab_wr = bus_wr && ix_ok && bus_ix == `DPLC_IX_STAB;
	// Refused (misaligned) writes must not strobe a commit either
	assign commit  = bus_wr && ix_ok && bus_ix == `DPLC_IX_CTRL &&
		pwdata[`DPLC_CTRL_COMMIT];

	always_comb
	begin
		ix_ok = paddr[1:0] == 2'h0;
		rd_data = 32'h0000_0000;
		case (bus_ix)
			`DPLC_IX_REFFREQ: rd_data = reg_ref_freq;
			`DPLC_IX_STAB:    rd_data = {8'h00, reg_stab};
			`DPLC_IX_CTRL:    rd_data = {31'h0000_0000, user_hold};
			`DPLC_IX_FTHR:    rd_data = {8'h00, reg_fthr};
			`DPLC_IX_RATE:    rd_data = {16'h0000, reg_rate};
			`DPLC_IX_CLMIN:   rd_data = {8'h00, reg_clmin};
			`DPLC_IX_CLMAX:   rd_data = {8'h00, reg_clmax};
			`DPLC_IX_HIST:    rd_data = {28'h000_0000, reg_hist};
			`DPLC_IX_STAT:
				rd_data = {23'h00_0000, active_ref, state,
					hist_valid, lock_q, internal_system_clock_stable, freq_locked};
			`DPLC_IX_AVG:     rd_data = {8'h00, hist_avg};
			default:          ix_ok = 1'b0;
		endcase
	end

	// One wait state: answer is built in the first access cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && !pwrite) ? rd_data : 32'h0000_0000;
			pslverr <= psel && penable && !pready && !ix_ok;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			reg_ref_freq <= 32'h0000_0000;
			reg_stab     <= 24'h00_0000;
			user_hold    <= 1'b0;
			reg_fthr     <= 24'h00_0000;
			reg_rate     <= `DPLC_RST_RATE;
			reg_clmin    <= 24'h00_0000;
			reg_clmax    <= `DPLC_RST_CLMAX;
			reg_hist     <= `DPLC_RST_HIST;
		end
		else if (bus_wr && ix_ok)
		begin
			case (bus_ix)
				`DPLC_IX_REFFREQ: reg_ref_freq <= pwdata;
				`DPLC_IX_STAB:    reg_stab <= pwdata[23:0];
				`DPLC_IX_CTRL:
					user_hold <= pwdata[`DPLC_CTRL_HOLD];
				`DPLC_IX_FTHR:    reg_fthr <= pwdata[23:0];
				`DPLC_IX_RATE:    reg_rate <= pwdata[15:0];
				`DPLC_IX_CLMIN:   reg_clmin <= pwdata[23:0];
				`DPLC_IX_CLMAX:   reg_clmax <= pwdata[23:0];
				`DPLC_IX_HIST:    reg_hist <= pwdata[3:0];
				default:          reg_hist <= reg_hist;
			endcase
		end
	end

	// Lock level changes count once second and third stages agree
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			lk_s1  <= 1'b0;
			lk_s2  <= 1'b0;
			lk_s3  <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			lk_s1 <= internal_system_clock_pll_locked;
			lk_s2 <= lk_s1;
			lk_s3 <= lk_s2;
			if (lk_s2 == lk_s3)
				lock_q <= lk_s3;
		end
	end

	// Armed at power-up so the first lock qualifies without a commit
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			armed         <= 1'b1;
			pres          <= 15'h0000;
			stab_cnt      <= 24'h00_0000;
			internal_system_clock_stable <= 1'b0;
		end
		else if (stab_wr)
		begin
			armed         <= 1'b0;
			pres          <= 15'h0000;
			stab_cnt      <= 24'h00_0000;
			internal_system_clock_stable <= 1'b0;
		end
		else if (!lock_q)
		begin
			pres          <= 15'h0000;
			stab_cnt      <= 24'h00_0000;
			internal_system_clock_stable <= 1'b0;
		end
		else if (!armed)
			armed <= commit;
		else if (stab_cnt >= reg_stab)
			internal_system_clock_stable <= 1'b1;
		else if (pres == 15'(TICK_CYCLES - 1))
		begin
			pres     <= 15'h0000;
			stab_cnt <= stab_cnt + 24'h00_0001;
		end
		else
			pres <= pres + 15'h0001;
	end

	// Reference monitors only count once the clock is qualified
	assign ref_ok   = ref_valid && internal_system_clock_stable;
	assign hold_req = !ref_ok || user_hold;

	always_comb
	begin
		next_state = state;
		case (state)
			dplc_st_free:
				if (!hold_req)
					next_state = dplc_st_recover;
			dplc_st_closed:
				if (hold_req)
					next_state = dplc_st_hold;
				else if (ref_select != active_ref)
					next_state = dplc_st_switch;
			dplc_st_hold:
				if (!hold_req)
					next_state = dplc_st_recover;
			dplc_st_switch:
				next_state = dplc_st_closed;
			dplc_st_recover:
				next_state = dplc_st_closed;
			default:
				next_state = dplc_st_free;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state       <= dplc_st_free;
			loop_state  <= dplc_st_free;
			active_ref  <= 2'h0;
			load_params <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			loop_state <= next_state;
			// Profile of the new reference is loaded on leaving
			load_params <= state == dplc_st_switch ||
				state == dplc_st_recover;
			if (state == dplc_st_switch || state == dplc_st_recover)
				active_ref <= ref_select;
		end
	end

	assign tw_clamped  = clamp_tw(lf_tw, reg_clmin, reg_clmax);
	assign avg_clamped = clamp_tw(hist_avg, reg_clmin, reg_clmax);

	// Switchover also rides on the average for its one cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tw_out <= 24'h00_0000;
		else if (state == dplc_st_closed || state == dplc_st_recover)
		begin
			if (lf_tw_valid)
				tw_out <= tw_clamped;
		end
		else
			tw_out <= avg_clamped;
	end

	assign hist_span = 16'h0001 << reg_hist;
	assign hist_sum  = hist_acc + {15'h0000, tw_clamped};

	// Only closed-loop words enter the history
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			hist_acc   <= 39'h00_0000_0000;
			hist_cnt   <= 15'h0000;
			hist_avg   <= 24'h00_0000;
			hist_valid <= 1'b0;
		end
		else if (state == dplc_st_closed && lf_tw_valid)
		begin
			if ({1'b0, hist_cnt} == hist_span - 16'h0001)
			begin
				hist_avg   <= 24'(hist_sum >> reg_hist);
				hist_valid <= 1'b1;
				hist_acc   <= 39'h00_0000_0000;
				hist_cnt   <= 15'h0000;
			end
			else
			begin
				hist_acc <= hist_sum;
				hist_cnt <= hist_cnt + 15'h0001;
			end
		end
	end

	assign dev_abs = period_dev[24] ? 25'(-period_dev) : period_dev;
	assign dev_mag = dev_abs[24] ? 24'hFF_FFFF : dev_abs[23:0];

	// Same level mechanism as the phase detector
	dplc_lock_det u_freq_det
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.sample_valid (period_dev_valid && internal_system_clock_stable),
		.sample_mag   (dev_mag),
		.threshold    (reg_fthr),
		.fill         (reg_rate[7:0]),
		.drain        (reg_rate[15:8]),
		.force_unlock (state == dplc_st_free ||
			state == dplc_st_hold),
		.freeze       (state == dplc_st_switch),
		.locked       (freq_locked)
	);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_hold_entry: assert property (
		state == dplc_st_closed && hold_req |=> state == dplc_st_hold)
		else $error("holdover not entered");

	a_user_hold_stays: assert property (
		state == dplc_st_hold && user_hold |=> state == dplc_st_hold)
		else $error("left holdover while user hold set");

	a_switch_brief: assert property (
		state == dplc_st_switch |=> state == dplc_st_closed ##0
		load_params && active_ref == $past(ref_select))
		else $error("switchover not one cycle");

	a_switch_lock_kept: assert property (
		state == dplc_st_switch |=> $stable(freq_locked))
		else $error("lock flag changed in switchover");

	a_hold_unlocked: assert property (
		state == dplc_st_hold |=> !freq_locked)
		else $error("locked during holdover");

	a_clamp_range: assert property (
		state == dplc_st_closed && lf_tw_valid &&
		reg_clmin <= reg_clmax && !bus_wr |=>
		tw_out >= reg_clmin && tw_out <= reg_clmax)
		else $error("tuning word outside clamp");

	a_stab_write: assert property (
		stab_wr |=> !internal_system_clock_stable && stab_cnt == 24'h00_0000 ##1
		!internal_system_clock_stable)
		else $error("period write did not reset timer");

	a_lock_loss: assert property (
		!lock_q |=> stab_cnt == 24'h00_0000 && !internal_system_clock_stable)
		else $error("timer ran without lock");

	a_hold_avg: assert property (
		state == dplc_st_hold && $stable(hist_avg) && !bus_wr
		|=> tw_out == avg_clamped)
		else $error("holdover word not the average");

endmodule // dplc_top

// ---- verification/dplc_ref_model.sv ----
// Reference and feedback path model: reference presence, one
// period-deviation strobe per comparison, loop-filter words.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/1ps

module dplc_ref_model
(
	// Clock
	input  wire logic        clock,
	// Toward the loop
	output logic             ref_valid,
	output logic             period_dev_valid,
	output logic [24:0]      period_dev,
	output logic             lf_tw_valid,
	output logic [23:0]      lf_tw
);
	initial
	begin
		ref_valid = 1'b0;
		period_dev_valid = 1'b0;
		period_dev = 25'h000_0000;
		lf_tw_valid = 1'b0;
		lf_tw = 24'h00_0000;
	end

	task automatic present(input logic v);
		ref_valid <= v;
	endtask

	// Between strobes the bus shows the inverse, never a stale value
	task automatic dev(input logic [24:0] d, input int gap);
		period_dev_valid <= 1'b1;
		period_dev <= d;
		@(posedge clock);
		period_dev_valid <= 1'b0;
		period_dev <= ~d;
		repeat (gap + 1) @(posedge clock);
	endtask

	task automatic tw(input logic [23:0] w);
		lf_tw_valid <= 1'b1;
		lf_tw <= w;
		@(posedge clock);
		lf_tw_valid <= 1'b0;
		lf_tw <= ~w;
		@(posedge clock);
	endtask
endmodule // dplc_ref_model

// ---- verification/dplc_top_test.sv ----
// Self-checking bench for the loop supervision block.
// Assumes the design asserts its own rules; drives APB and lock.
`timescale 1ns/1ps
`include "dplc_defines.svh"

module dplc_top_test
	import dplc_pkg::*;
;
	typedef struct
	{
		logic [15:0] ix;
		logic        wr;
		logic [31:0] wd;
		logic [31:0] ex;
	} dplc_row_t;

	localparam logic [24:0] GOOD = 25'h1FF_FC18;
	localparam logic [24:0] BAD  = 25'h000_03E9;

	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        internal_system_clock_pll_locked;
	logic        ref_valid;
	logic [1:0]  ref_select;
	logic        period_dev_valid;
	logic [24:0] period_dev;
	logic        lf_tw_valid;
	logic [23:0] lf_tw;
	logic [23:0] tw_out;
	logic        freq_locked;
	dplc_state_t loop_state;
	logic [1:0]  active_ref;
	logic        load_params;
	logic        internal_system_clock_stable;
	logic [31:0] rd;
	logic        er;
	int          checks;
	int          mismatches;
	int          n;
	int          sw;
	int          lp;
	int          dr;
	dplc_row_t   rows [11];

	dplc_top #(.TICK_CYCLES(4)) dut
	(
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.internal_system_clock_pll_locked(internal_system_clock_pll_locked), .ref_valid(ref_valid),
		.ref_select(ref_select), .period_dev_valid(period_dev_valid),
		.period_dev(period_dev), .lf_tw_valid(lf_tw_valid),
		.lf_tw(lf_tw), .tw_out(tw_out), .freq_locked(freq_locked),
		.loop_state(loop_state), .active_ref(active_ref),
		.load_params(load_params), .internal_system_clock_stable(internal_system_clock_stable)
	);

	dplc_ref_model rm
	(
		.clock(clock), .ref_valid(ref_valid),
		.period_dev_valid(period_dev_valid), .period_dev(period_dev),
		.lf_tw_valid(lf_tw_valid), .lf_tw(lf_tw)
	);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic chk(input string s, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tmo();
		mismatches++;
		give_verdict();
	endtask

	task automatic apb(input logic w, input logic [17:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'b1 && k < 40);
		if (k >= 40)
			tmo();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wstable();
		n = 0;
		while (internal_system_clock_stable !== 1'b1 && n < 200)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= 200)
			tmo();
	endtask

	task automatic drive(input logic lk, input logic [1:0] rs);
		internal_system_clock_pll_locked <= lk;
		ref_select <= rs;
	endtask

	initial
	begin
		checks = 0;
		mismatches = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h0_0000;
		pwdata = 32'h0000_0000;
		internal_system_clock_pll_locked = 1'b0;
		ref_select = 2'h0;
		rows = '{
			'{`DPLC_IX_CLMAX, 1'b0, 32'h0000_0000, 32'h00FF_FFFF},
			'{`DPLC_IX_RATE, 1'b0, 32'h0000_0000, 32'h0000_0101},
			'{`DPLC_IX_HIST, 1'b0, 32'h0000_0000, 32'h0000_0004},
			'{`DPLC_IX_CLMIN, 1'b0, 32'h0000_0000, 32'h0000_0000},
			'{`DPLC_IX_REFFREQ, 1'b1, 32'h1234_5678, 32'h1234_5678},
			'{`DPLC_IX_FTHR, 1'b1, 32'hFF00_03E8, 32'h0000_03E8},
			'{`DPLC_IX_RATE, 1'b1, 32'h0000_FFFF, 32'h0000_FFFF},
			'{`DPLC_IX_CLMIN, 1'b1, 32'h0010_0000, 32'h0010_0000},
			'{`DPLC_IX_CLMAX, 1'b1, 32'h0020_0000, 32'h0020_0000},
			'{`DPLC_IX_CTRL, 1'b1, 32'h0000_0002, 32'h0000_0000},
			'{`DPLC_IX_STAB, 1'b1, 32'h0000_0003, 32'h0000_0003}};
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk("state", 32'(loop_state), 32'(dplc_st_free));
		chk("stable", 32'(internal_system_clock_stable), 32'h0000_0000);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				apb(1'b1, {rows[i].ix, 2'b00}, rows[i].wd);
			apb(1'b0, {rows[i].ix, 2'b00}, 32'h0000_0000);
			chk("reg", rd, rows[i].ex);
		end
		// Unmapped and misaligned accesses are refused
		apb(1'b0, 18'h0_0400, 32'h0000_0000);
		chk("unmapped", {rd[30:0], er}, 32'h0000_0001);
		apb(1'b1, {`DPLC_IX_FTHR, 2'b01}, 32'h0000_0005);
		chk("misaligned", 32'(er), 32'h0000_0001);
		apb(1'b0, {`DPLC_IX_FTHR, 2'b00}, 32'h0000_0000);
		chk("fthr", rd, 32'h0000_03E8);
		rm.present(1'b1);
		repeat (3) @(posedge clock);
		// Reference monitor is gated until the clock is qualified
		chk("nomon", 32'(loop_state), 32'(dplc_st_free));
		repeat (20) rm.dev(GOOD, 1);
		repeat (4) @(posedge clock);
		chk("gated", 32'(freq_locked), 32'h0000_0000);
		// Period was written after the last commit: lock alone waits
		drive(1'b1, 2'h0);
		repeat (30) @(posedge clock);
		chk("armed", 32'(internal_system_clock_stable), 32'h0000_0000);
		apb(1'b1, {`DPLC_IX_CTRL, 2'b00}, 32'h0000_0002);
		wstable();
		chk("delay", 32'(n >= 12), 32'h0000_0001);
		@(posedge clock);
		chk("recover", 32'(loop_state), 32'(dplc_st_recover));
		drive(1'b0, 2'h0);
		repeat (10) @(posedge clock);
		chk("loss", 32'(internal_system_clock_stable), 32'h0000_0000);
		drive(1'b1, 2'h0);
		repeat (10) @(posedge clock);
		drive(1'b0, 2'h0);
		repeat (10) @(posedge clock);
		drive(1'b1, 2'h0);
		wstable();
		chk("restart", 32'(n >= 16), 32'h0000_0001);
		repeat (12) rm.dev(GOOD, 1);
		repeat (4) @(posedge clock);
		chk("fill12", 32'(freq_locked), 32'h0000_0000);
		rm.dev(GOOD, 3);
		repeat (4) @(posedge clock);
		chk("fill13", 32'(freq_locked), 32'h0000_0001);
		repeat (5) rm.dev(GOOD, 1);
		n = 0;
		while (loop_state !== dplc_st_closed && n < 2000)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= 2000)
			tmo();
		rm.tw(24'h30_0000);
		chk("clamp_hi", 32'(tw_out), 32'h0020_0000);
		rm.tw(24'h00_0001);
		chk("clamp_lo", 32'(tw_out), 32'h0010_0000);
		repeat (32) rm.tw(24'h15_5555);
		// Switch must keep the lock indication through the transition
		drive(1'b1, 2'h1);
		sw = 0;
		lp = 0;
		dr = 0;
		repeat (6)
		begin
			@(posedge clock);
			sw += int'(loop_state === dplc_st_switch);
			lp += int'(load_params === 1'b1);
			dr += int'(freq_locked !== 1'b1);
		end
		chk("switch", 32'(sw), 32'h0000_0001);
		chk("load", 32'(lp), 32'h0000_0001);
		chk("held", 32'(dr), 32'h0000_0000);
		chk("aref", {30'h0, active_ref}, 32'h0000_0001);
		repeat (12) rm.dev(BAD, 1);
		repeat (4) @(posedge clock);
		chk("drain12", 32'(freq_locked), 32'h0000_0001);
		rm.dev(BAD, 3);
		repeat (4) @(posedge clock);
		chk("drain13", 32'(freq_locked), 32'h0000_0000);
		repeat (13) rm.dev(GOOD, 1);
		apb(1'b1, {`DPLC_IX_CTRL, 2'b00}, 32'h0000_0001);
		rm.tw(24'h1F_0000);
		repeat (20) @(posedge clock);
		chk("hold", 32'(loop_state), 32'(dplc_st_hold));
		chk("unlock", 32'(freq_locked), 32'h0000_0000);
		chk("avg", 32'(tw_out), 32'h0015_5555);
		apb(1'b0, {`DPLC_IX_AVG, 2'b00}, 32'h0000_0000);
		chk("avg_reg", rd, 32'h0015_5555);
		// Ref 1, hold, history valid, PLL locked, stable, unlocked
		apb(1'b0, {`DPLC_IX_STAT, 2'b00}, 32'h0000_0000);
		chk("status", rd, 32'h0000_00AE);
		apb(1'b1, {`DPLC_IX_CTRL, 2'b00}, 32'h0000_0000);
		@(posedge clock);
		chk("resume", 32'(loop_state), 32'(dplc_st_recover));
		rm.present(1'b0);
		repeat (3) @(posedge clock);
		chk("noref", 32'(loop_state), 32'(dplc_st_hold));
		apb(1'b1, {`DPLC_IX_STAB, 2'b00}, 32'h0000_0001);
		chk("rewrite", 32'(internal_system_clock_stable), 32'h0000_0000);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk("rst", {tw_out, 5'h0, loop_state}, 32'h0000_0000);
		give_verdict();
	end
endmodule // dplc_top_test
